// ---- dv/bce_fetch_model.sv ----
// next-pc side model that follows each branch result
`timescale 1ns/100ps
module bce_fetch_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic res_valid_in,
	input wire logic [31:0] next_pc_in,
	output logic [31:0] fetch_pc_out
);
	// redirect only on a result; held values between results are not trusted
	always_ff @(posedge clk_in) begin
		if (rst_in)
			fetch_pc_out <= 32'h00000000;
		else if (res_valid_in)
			fetch_pc_out <= next_pc_in;
	end
endmodule

// ---- dv/bce_monitor.sv ----
// port assertions for the branch condition evaluator
`timescale 1ns/100ps
module bce_monitor (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic br_valid_in,
	input wire logic [4:0] br_options_in,
	input wire bce_pkg::bce_form_t br_form_in,
	input wire logic [1:0] br_hint_field_in,
	input wire logic [31:0] br_pc_in,
	input wire logic [31:0] br_target_in,
	input wire logic res_valid_out,
	input wire logic res_taken_out,
	input wire logic res_predict_out,
	input wire logic [1:0] res_hint_field_out,
	input wire logic [31:0] res_next_pc_out
);
	import bce_pkg::*;
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	AST_APB_WAIT: assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("pready late");
	AST_APB_ONE: assert property (pready_out |=> !pready_out) else $error("pready too long");
	AST_ERR_RDY: assert property (pslverr_out |-> pready_out) else $error("pslverr without pready");
	AST_NO_RES: assert property (!br_valid_in |=> !res_valid_out) else $error("result without branch");
	AST_ALWAYS: assert property (res_valid_out && $past(br_options_in) == 5'h14 |-> res_taken_out)
		else $error("options 20 not taken");
	AST_PREDICT: assert property (res_valid_out |-> {4'h0, res_predict_out} == ($past(br_options_in) & 5'h01))
		else $error("predict bit wrong");
	AST_HINT: assert property (res_valid_out |-> res_hint_field_out == $past(br_hint_field_in))
		else $error("hint field altered");
	AST_FALL_PC: assert property (res_valid_out && !res_taken_out |-> res_next_pc_out == $past(br_pc_in) + 32'h4)
		else $error("fall through pc wrong");
	AST_ABS_PC: assert property (res_valid_out && res_taken_out && $past(br_form_in) == BCE_FORM_ABSOLUTE
		|-> res_next_pc_out == $past(br_target_in)) else $error("absolute target wrong");
	AST_HOLD: assert property (!res_valid_out |-> $stable(res_next_pc_out) && $stable(res_taken_out))
		else $error("result moved without valid");
	// main scenarios seen
	cover property (res_valid_out && res_taken_out);
	cover property (res_valid_out && !res_taken_out);
	cover property (pslverr_out);
endmodule
bind bce_top bce_monitor u_mon (.sys_clk_in, .rst_in, .psel_in, .penable_in, .pready_out, .pslverr_out,
	.br_valid_in, .br_options_in, .br_form_in, .br_hint_field_in, .br_pc_in, .br_target_in, .res_valid_out,
	.res_taken_out, .res_predict_out, .res_hint_field_out, .res_next_pc_out);

// ---- dv/test_bce_top.sv ----
// self-checking bench for the branch condition evaluator
`timescale 1ns/100ps
module test_bce_top;
	import bce_pkg::*;
	logic sys_clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, err;
	logic cmp_valid_in = 1'b0, cmp_lt_in = 1'b0, cmp_gt_in = 1'b0, cmp_eq_in = 1'b0, cmp_so_un_in = 1'b0;
	logic br_valid_in = 1'b0, br_link_in = 1'b0, pready_out, pslverr_out, res_valid_out, res_taken_out;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, br_pc_in = 32'h0, br_target_in = 32'h0, prdata_out, res_next_pc_out, fetch_pc, rd;
	logic [2:0] cmp_field_in = 3'h0;
	logic [4:0] br_options_in = 5'h00, br_bit_sel_in = 5'h00;
	logic [1:0] br_hint_field_in = 2'h0, res_hint_field_out;
	logic res_predict_out;
	bce_form_t br_form_in = BCE_FORM_RELATIVE;
	int miscompares = 0, num_checks = 0;
	// 25 MHz clock
	always #20 sys_clk_in = ~sys_clk_in;
	bce_top dut (.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
		.pready_out, .pslverr_out, .cmp_valid_in, .cmp_field_in, .cmp_lt_in, .cmp_gt_in, .cmp_eq_in, .cmp_so_un_in,
		.br_valid_in, .br_options_in, .br_bit_sel_in, .br_form_in, .br_link_in, .br_hint_field_in, .br_pc_in,
		.br_target_in, .res_valid_out, .res_taken_out, .res_predict_out, .res_hint_field_out, .res_next_pc_out);
	bce_fetch_model u_fetch (.clk_in(sys_clk_in), .rst_in, .res_valid_in(res_valid_out),
		.next_pc_in(res_next_pc_out), .fetch_pc_out(fetch_pc));
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// four-state compare of one result word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is sampled high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		n = 0;
		// values read right after the edge are the ones that edge sampled
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		chk({31'h0, pready_out}, 32'h1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	// one branch, optionally with a compare in the same cycle; v is the expected result pulse
	task automatic br(input logic [4:0] o, s, input bce_form_t f, input logic l, input logic [31:0] pc, t,
		input logic c, v);
		@(posedge sys_clk_in);
		br_valid_in <= 1'b1;
		cmp_valid_in <= c;
		br_options_in <= o;
		br_bit_sel_in <= s;
		br_form_in <= f;
		br_link_in <= l;
		br_hint_field_in <= s[1:0];
		br_pc_in <= pc;
		br_target_in <= t;
		@(posedge sys_clk_in);
		br_valid_in <= 1'b0;
		cmp_valid_in <= 1'b0;
		#1;
		chk({31'h0, res_valid_out}, {31'h0, v});
		if (v)
			chk({30'h0, res_hint_field_out}, {30'h0, s[1:0]});
	endtask
	// expected outcome: bit4 ignores condition, bit3 wanted value, bit2 keeps count, bit1 wants zero
	function automatic logic take(input logic [4:0] o, input logic c, input logic [31:0] n);
		return (o[2] || ((n == 0) == o[1])) && (o[4] || (c == o[3]));
	endfunction
	// reset values, unmapped address, read-only status
	task automatic t_reset();
		logic [31:0] e [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, e[i]);
		end
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, BCE_ADDR_STATUS, 32'h7);
		apb(1'b0, BCE_ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
	endtask
	// compares fill all eight fields back to back, then a same-cycle compare and branch
	task automatic t_flags();
		logic [31:0] e = 32'h0;
		for (int f = 0; f < 8; f++) begin
			@(posedge sys_clk_in);
			cmp_valid_in <= 1'b1;
			cmp_field_in <= 3'(f);
			{cmp_so_un_in, cmp_eq_in, cmp_gt_in, cmp_lt_in} <= 4'(f + 9);
			e[4 * f +: 4] = 4'(f + 9);
		end
		@(posedge sys_clk_in);
		cmp_valid_in <= 1'b0;
		cmp_field_in <= 3'h5;
		{cmp_so_un_in, cmp_eq_in, cmp_gt_in, cmp_lt_in} <= 4'h0;
		apb(1'b0, BCE_ADDR_FLAGS, 32'h0);
		chk(rd, e);
		br(5'h0C, 5'd22, BCE_FORM_ABSOLUTE, 1'b0, 32'h100, 32'h900, 1'b1, 1'b1);
		chk({31'h0, res_taken_out}, 32'h0);
	endtask
	// every options code with both condition values and both predict bits, and counts ending zero or not on the codes that decrement
	task automatic t_cond();
		logic [4:0] ops [9] = '{5'h0C, 5'h04, 5'h08, 5'h00, 5'h0A, 5'h02, 5'h12, 5'h10, 5'h14};
		logic [4:0] s;
		logic [31:0] n;
		for (int i = 0; i < 72; i++) begin
			s = 5'(i * 7);
			apb(1'b1, BCE_ADDR_FLAGS, i[1] ? 32'h1 << s : ~(32'h1 << s));
			apb(1'b1, BCE_ADDR_CTR, 32'(1 + i[2]));
			br(ops[i / 8] | 5'(i[0]), s, BCE_FORM_ABSOLUTE, 1'b0, 32'h100, 32'h2000, 1'b0, 1'b1);
			n = ops[i / 8][2] ? 32'(1 + i[2]) : 32'(i[2]);
			chk({31'h0, res_taken_out}, {31'h0, take(ops[i / 8], i[1], n)});
			chk({31'h0, res_predict_out}, 32'(i[0]));
			apb(1'b0, BCE_ADDR_CTR, 32'h0);
			chk(rd, n);
		end
	endtask
	// target forms, link update, and branches refused while disabled
	task automatic t_forms();
		apb(1'b1, BCE_ADDR_CTR, 32'h40);
		br(5'h14, 5'h0, BCE_FORM_ABSOLUTE, 1'b1, 32'h300, 32'h5000, 1'b0, 1'b1);
		chk(res_next_pc_out, 32'h5000);
		apb(1'b0, BCE_ADDR_LINK, 32'h0);
		chk(rd, 32'h304);
		chk(fetch_pc, 32'h5000);
		br(5'h14, 5'h0, BCE_FORM_TO_LINK, 1'b0, 32'h600, 32'h0, 1'b0, 1'b1);
		chk(res_next_pc_out, 32'h304);
		br(5'h14, 5'h0, BCE_FORM_TO_COUNT, 1'b0, 32'h600, 32'h0, 1'b0, 1'b1);
		chk(res_next_pc_out, 32'h40);
		br(5'h14, 5'h0, BCE_FORM_RELATIVE, 1'b0, 32'h600, 32'h20, 1'b0, 1'b1);
		chk(res_next_pc_out, 32'h620);
		apb(1'b1, BCE_ADDR_CTRL, 32'h0);
		br(5'h10, 5'h0, BCE_FORM_RELATIVE, 1'b0, 32'h600, 32'h20, 1'b0, 1'b0);
		apb(1'b0, BCE_ADDR_CTR, 32'h0);
		chk(rd, 32'h40);
		apb(1'b0, BCE_ADDR_STATUS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, BCE_ADDR_CTRL, 32'h1);
	endtask
	// reset for twelve cycles, then the scenarios
	initial begin
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_flags();
		t_cond();
		t_forms();
		test_done();
	end
	// watchdog: 10000 cycles, about nine times the roughly 1100 the scenarios need
	initial begin
		#400000;
		miscompares++;
		test_done();
	end
endmodule

// ---- inc/bce_pkg.sv ----
// shared constants and types of the branch condition evaluator
package bce_pkg;
	localparam int unsigned BCE_DATA_W = 32;
	localparam int unsigned BCE_FIELDS = 8;
	localparam int unsigned BCE_FIELD_W = 4;
	localparam int unsigned BCE_SEL_W = 5;
	localparam int unsigned BCE_OPT_W = 5;
	localparam int unsigned BCE_FNUM_W = 3;
	// positions inside one 4-bit condition field
	localparam int unsigned BCE_POS_LT = 0;
	localparam int unsigned BCE_POS_GT = 1;
	localparam int unsigned BCE_POS_EQ = 2;
	localparam int unsigned BCE_POS_SO = 3;
	// branch options field bits, value 16 down to value 1
	localparam int unsigned BCE_OPT_IGNORE_COND = 4;
	localparam int unsigned BCE_OPT_COND_VALUE = 3;
	localparam int unsigned BCE_OPT_NO_DECR = 2;
	localparam int unsigned BCE_OPT_CTR_ZERO = 1;
	localparam int unsigned BCE_OPT_PREDICT = 0;
	// register byte addresses
	localparam logic [7:0] BCE_ADDR_FLAGS = 8'h00;
	localparam logic [7:0] BCE_ADDR_CTR = 8'h04;
	localparam logic [7:0] BCE_ADDR_LINK = 8'h08;
	localparam logic [7:0] BCE_ADDR_CTRL = 8'h0C;
	localparam logic [7:0] BCE_ADDR_STATUS = 8'h10;
	// reset values
	localparam logic [31:0] BCE_RST_FLAGS = 32'h00000000;
	localparam logic [31:0] BCE_RST_CTR = 32'h00000000;
	localparam logic [31:0] BCE_RST_LINK = 32'h00000000;
	localparam logic [31:0] BCE_RST_CTRL = 32'h00000001;
	// control and status bit positions
	localparam int unsigned BCE_CTRL_ENABLE = 0;
	localparam int unsigned BCE_STAT_TAKEN = 0;
	localparam int unsigned BCE_STAT_PREDICT = 1;
	localparam int unsigned BCE_STAT_CTR_ZERO = 2;
	localparam logic [31:0] BCE_PC_STEP = 32'h00000004;
	// branch target forms
	typedef enum logic [1:0] {
		BCE_FORM_RELATIVE = 2'h0,
		BCE_FORM_ABSOLUTE = 2'h1,
		BCE_FORM_TO_LINK = 2'h2,
		BCE_FORM_TO_COUNT = 2'h3
	} bce_form_t;
endpackage

// ---- rtl/bce_bit_select.sv ----
// picks one condition bit out of the condition flags word
`timescale 1ns/100ps
module bce_bit_select #(
	parameter int unsigned FIELDS = 8,
	parameter int unsigned FIELD_W = 4
) (
	input wire logic [FIELDS*FIELD_W-1:0] flags_in,
	input wire logic [4:0] bit_sel_in,
	output logic bit_out
);
	import bce_pkg::*;

	// the index arithmetic below assumes 8 fields of 4 bits
	if (FIELDS * FIELD_W != BCE_DATA_W || FIELD_W != BCE_FIELD_W) begin : g_bad
		$error("bce_bit_select: unsupported field layout");
	end

	logic [2:0] field_num;
	logic [1:0] field_pos;
	logic [3:0] field_bits;

	// index = 4 * field + position, field 0 in the low bits
	always_comb begin
		field_num = bit_sel_in[4:2];
		field_pos = bit_sel_in[1:0];
		field_bits = flags_in[field_num*FIELD_W +: FIELD_W];
		bit_out = field_bits[field_pos];
	end
endmodule

// ---- rtl/bce_option_decode.sv ----
// splits the branch options field into its control meanings
`timescale 1ns/100ps
module bce_option_decode (
	input wire logic [4:0] options_in,
	output logic decrement_out,
	output logic want_ctr_zero_out,
	output logic use_cond_out,
	output logic cond_value_out,
	output logic predict_out
);
	import bce_pkg::*;

	// decoding by bit covers 12, 04, 08, 00, 10, 02, 18, 16 and 20 alike
	always_comb begin
		decrement_out = ~options_in[BCE_OPT_NO_DECR];
		want_ctr_zero_out = options_in[BCE_OPT_CTR_ZERO];
		use_cond_out = ~options_in[BCE_OPT_IGNORE_COND];
		cond_value_out = options_in[BCE_OPT_COND_VALUE];
		// hint bit leaves the taken decision alone
		predict_out = options_in[BCE_OPT_PREDICT];
	end
endmodule

// ---- rtl/bce_top.sv ----
// branch condition evaluator with flags, loop count and link registers on APB
`timescale 1ns/100ps
module bce_top (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// compare unit result
	input wire logic cmp_valid_in,
	input wire logic [bce_pkg::BCE_FNUM_W-1:0] cmp_field_in,
	input wire logic cmp_lt_in,
	input wire logic cmp_gt_in,
	input wire logic cmp_eq_in,
	input wire logic cmp_so_un_in,
	// conditional branch from decode
	input wire logic br_valid_in,
	input wire logic [bce_pkg::BCE_OPT_W-1:0] br_options_in,
	input wire logic [bce_pkg::BCE_SEL_W-1:0] br_bit_sel_in,
	input wire bce_pkg::bce_form_t br_form_in,
	input wire logic br_link_in,
	input wire logic [1:0] br_hint_field_in,
	input wire logic [31:0] br_pc_in,
	input wire logic [31:0] br_target_in,
	// result towards next-pc logic
	output logic res_valid_out,
	output logic res_taken_out,
	output logic res_predict_out,
	output logic [1:0] res_hint_field_out,
	output logic [31:0] res_next_pc_out
);
	import bce_pkg::*;

	logic [31:0] flags_q;
	logic [31:0] flags_d;
	logic [31:0] ctr_q;
	logic [31:0] ctr_d;
	logic [31:0] link_q;
	logic [31:0] link_d;
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [2:0] stat_q;
	logic [2:0] stat_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic res_valid_q;
	logic res_valid_d;
	logic res_taken_q;
	logic res_taken_d;
	logic res_predict_q;
	logic res_predict_d;
	logic [1:0] res_hint_q;
	logic [1:0] res_hint_d;
	logic [31:0] res_pc_q;
	logic [31:0] res_pc_d;

	logic [31:0] flags_live;
	logic [3:0] cmp_field_bits;
	logic cond_bit;
	logic opt_decrement;
	logic opt_want_zero;
	logic opt_use_cond;
	logic opt_cond_value;
	logic opt_predict;
	logic do_decrement;
	logic [31:0] ctr_next;
	logic ctr_is_zero;
	logic ctr_ok;
	logic cond_ok;
	logic br_go;
	logic taken;
	logic [31:0] taken_pc;
	logic apb_access;
	logic apb_write;
	logic addr_hit;

	// compare result laid into its field, same bit order for integer and float
	always_comb begin
		cmp_field_bits = '0;
		cmp_field_bits[BCE_POS_LT] = cmp_lt_in;
		cmp_field_bits[BCE_POS_GT] = cmp_gt_in;
		cmp_field_bits[BCE_POS_EQ] = cmp_eq_in;
		cmp_field_bits[BCE_POS_SO] = cmp_so_un_in;
	end

	// bypass a same-cycle compare so the branch sees the newest flags
	// without it a compare and a branch in one cycle would test a stale bit
	always_comb begin
		flags_live = flags_q;
		if (cmp_valid_in) begin
			flags_live[cmp_field_in*BCE_FIELD_W +: BCE_FIELD_W] = cmp_field_bits;
		end
	end

	bce_bit_select #(
		.FIELDS(BCE_FIELDS),
		.FIELD_W(BCE_FIELD_W)
	) u_bit_select (
		.flags_in(flags_live),
		.bit_sel_in(br_bit_sel_in),
		.bit_out(cond_bit)
	);

	bce_option_decode u_option_decode (
		.options_in(br_options_in),
		.decrement_out(opt_decrement),
		.want_ctr_zero_out(opt_want_zero),
		.use_cond_out(opt_use_cond),
		.cond_value_out(opt_cond_value),
		.predict_out(opt_predict)
	);

	// taken decision; the to-count form never decrements since the count is its target
	always_comb begin
		br_go = br_valid_in & ctrl_q[BCE_CTRL_ENABLE];
		do_decrement = opt_decrement & (br_form_in != BCE_FORM_TO_COUNT);
		// a count of zero wraps to all ones and keeps looping
		ctr_next = do_decrement ? ctr_q - 32'h00000001 : ctr_q;
		ctr_is_zero = (ctr_next == 32'h00000000);
		// test the count after the decrement, not before
		ctr_ok = ~do_decrement | (ctr_is_zero == opt_want_zero);
		// negated codes compare the positive bit against 0
		cond_ok = ~opt_use_cond | (cond_bit == opt_cond_value);
		// prediction bit deliberately absent from this term
		taken = ctr_ok & cond_ok;
	end

	// target selection by form
	// relative form adds a displacement that decode has already sign extended
	always_comb begin
		case (br_form_in)
			BCE_FORM_RELATIVE: taken_pc = br_pc_in + br_target_in;
			BCE_FORM_ABSOLUTE: taken_pc = br_target_in;
			BCE_FORM_TO_LINK: taken_pc = link_q;
			BCE_FORM_TO_COUNT: taken_pc = ctr_q;
			default: taken_pc = br_target_in;
		endcase
	end

	// result stage towards fetch
	// outputs hold between results so the fetch side may read them late
	always_comb begin
		res_valid_d = br_go;
		res_taken_d = res_taken_q;
		res_predict_d = res_predict_q;
		res_hint_d = res_hint_q;
		res_pc_d = res_pc_q;
		if (br_go) begin
			res_taken_d = taken;
			res_predict_d = opt_predict;
			// hint only travels along, extended forms supply 0b00
			res_hint_d = br_hint_field_in;
			res_pc_d = taken ? taken_pc : br_pc_in + BCE_PC_STEP;
		end
	end

	// apb decode: one wait state so that all answers come from flops
	always_comb begin
		apb_access = psel_in & penable_in;
		// a write lands only at the edge where pready is sampled high
		apb_write = apb_access & pready_q & pwrite_in;
		case (paddr_in)
			BCE_ADDR_FLAGS, BCE_ADDR_CTR, BCE_ADDR_LINK, BCE_ADDR_CTRL, BCE_ADDR_STATUS: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
		// pready_q blocks a second answer while the master still holds its access
		pready_d = apb_access & ~pready_q;
		// unmapped addresses still get the wait state, then an error
		pslverr_d = apb_access & ~pready_q & ~addr_hit;
		prdata_d = 32'h00000000;
		if (apb_access & ~pready_q & ~pwrite_in) begin
			case (paddr_in)
				BCE_ADDR_FLAGS: prdata_d = flags_q;
				BCE_ADDR_CTR: prdata_d = ctr_q;
				BCE_ADDR_LINK: prdata_d = link_q;
				BCE_ADDR_CTRL: prdata_d = ctrl_q;
				BCE_ADDR_STATUS: prdata_d = {29'h00000000, stat_q};
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	// register file; hardware updates win over a software write in the same cycle
	always_comb begin
		flags_d = flags_q;
		ctr_d = ctr_q;
		link_d = link_q;
		ctrl_d = ctrl_q;
		stat_d = stat_q;
		if (apb_write) begin
			case (paddr_in)
				BCE_ADDR_FLAGS: flags_d = pwdata_in;
				BCE_ADDR_CTR: ctr_d = pwdata_in;
				BCE_ADDR_LINK: link_d = pwdata_in;
				BCE_ADDR_CTRL: ctrl_d = {31'h00000000, pwdata_in[BCE_CTRL_ENABLE]};
				// status is read only, so a write to it falls through here
				default: ;
			endcase
		end
		if (cmp_valid_in) begin
			flags_d = flags_live;
		end
		if (br_go) begin
			// written back whether or not the branch goes
			ctr_d = ctr_next;
			// link follows every linking branch, taken or not
			if (br_link_in) begin
				link_d = br_pc_in + BCE_PC_STEP;
			end
			// status keeps the last evaluated branch for software to inspect
			stat_d[BCE_STAT_TAKEN] = taken;
			stat_d[BCE_STAT_PREDICT] = opt_predict;
			stat_d[BCE_STAT_CTR_ZERO] = (ctr_next == 32'h00000000);
		end
	end

	// flag, count, link, control and status registers
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			flags_q <= BCE_RST_FLAGS;
			ctr_q <= BCE_RST_CTR;
			link_q <= BCE_RST_LINK;
			ctrl_q <= BCE_RST_CTRL;
			stat_q <= 3'h0;
		end else begin
			flags_q <= flags_d;
			ctr_q <= ctr_d;
			link_q <= link_d;
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
		end
	end

	// bus answer registers, kept apart so bus timing can change without touching state
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// result registers towards fetch
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			res_valid_q <= 1'b0;
			res_taken_q <= 1'b0;
			res_predict_q <= 1'b0;
			res_hint_q <= 2'h0;
			res_pc_q <= 32'h00000000;
		end else begin
			res_valid_q <= res_valid_d;
			res_taken_q <= res_taken_d;
			res_predict_q <= res_predict_d;
			res_hint_q <= res_hint_d;
			res_pc_q <= res_pc_d;
		end
	end

	// outputs straight from flops
	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign res_valid_out = res_valid_q;
	assign res_taken_out = res_taken_q;
	assign res_predict_out = res_predict_q;
	assign res_hint_field_out = res_hint_q;
	assign res_next_pc_out = res_pc_q;
endmodule
